/* File: verilog/bpo_port_option_ctrl.sv */
// Port option and retry limit registers with the retry attempt counter.
//
// Contract
// - Read alias bits let line/multiple reads match.
// - Write alias bits let invalidate writes match.
// - Invalidate bit clear converts to plain write.
// - Invalidate bit set disconnects at line boundaries.
// - Bit 9 enables long request for locks.
// - Bit 10 sets secondary master request hold.
// - Bit 11 sets primary master request hold.
// - Reserved option bits read zero, ignore writes.
// - Retry limit register, default two to 24.
// - Posted write failure sets flag, system error.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "bpo_defs.svh"
module bpo_port_option_ctrl
	import bpo_pkg::*;
(
	// Clock and reset.
	input  wire logic             sys_clk_i,
	input  wire logic             reset_i,
	// Avalon-MM slave.
	input  wire logic [7:0]       avs_address_i,
	input  wire logic             avs_read_i,
	input  wire logic             avs_write_i,
	input  wire logic [31:0]      avs_writedata_i,
	input  wire logic [3:0]       avs_byteenable_i,
	output logic [31:0]           avs_readdata_o,
	output logic                  avs_waitrequest_o,
	// Primary and secondary side traffic.
	input  wire bpo_side_in_type  pri_side_i,
	input  wire bpo_side_in_type  sec_side_i,
	output bpo_side_out_type      pri_side_o,
	output bpo_side_out_type      sec_side_o,
	// Retry sequencing of the queued transaction.
	input  wire logic             txn_start_i,
	input  wire logic             txn_retry_i,
	input  wire logic             txn_done_i,
	input  wire logic             txn_posted_i,
	output logic                  retry_stop_o,
	output logic                  retry_timeout_o,
	// Error and interrupt.
	output logic                  primary_system_error_n_o,
	output logic                  irq_o
);
	typedef struct packed {
		logic [15:0]   port_option;
		logic [31:0]   retry_limit;
		logic [1:0]    evt_status;
		logic [1:0]    evt_mask;
		logic [31:0]   attempts;
		bpo_state_type state;
		logic          posted;
		logic          timeout_pulse;
		logic          ack;
		logic [31:0]   rdata;
	} bpo_regs_type;

	bpo_regs_type r;
	bpo_regs_type next_r;
	logic         req;
	logic         access;
	logic         commit;
	logic [31:0]  wmask;
	logic [1:0]   evt_set;
	logic [31:0]  rd_mux;

	bpo_side_ctrl u_pri (
		.rd_alias_i  (r.port_option[`BPO_PRI_RD_ALIAS]),
		.wr_alias_i  (r.port_option[`BPO_PRI_WR_ALIAS]),
		.wi_disc_i   (r.port_option[`BPO_PRI_WI_DISC]),
		.hold_req_i  (r.port_option[`BPO_PRI_HOLD_REQ]),
		.long_lock_i (r.port_option[`BPO_LONG_LOCK]),
		.side_i      (pri_side_i),
		.side_o      (pri_side_o)
	);

	bpo_side_ctrl u_sec (
		.rd_alias_i  (r.port_option[`BPO_SEC_RD_ALIAS]),
		.wr_alias_i  (r.port_option[`BPO_SEC_WR_ALIAS]),
		.wi_disc_i   (r.port_option[`BPO_SEC_WI_DISC]),
		.hold_req_i  (r.port_option[`BPO_SEC_HOLD_REQ]),
		.long_lock_i (r.port_option[`BPO_LONG_LOCK]),
		.side_i      (sec_side_i),
		.side_o      (sec_side_o)
	);

	// Each request waits one cycle so read data come from a register.
	// Writes land at the edge where waitrequest is seen low, where the bus
	// places the transfer, so a written value never shows a cycle early.
	assign req = avs_read_i || avs_write_i;
	assign access = req && !r.ack;
	assign commit = req && r.ack;
	assign avs_waitrequest_o = access;
	assign avs_readdata_o = r.rdata;
	assign retry_stop_o = r.state == BPO_EXPIRED;
	assign retry_timeout_o = r.timeout_pulse;
	assign primary_system_error_n_o =
		!r.evt_status[`BPO_EVT_POSTED_FAIL];
	assign irq_o = |(r.evt_status & r.evt_mask);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
		end
	endgenerate

	always_comb begin
		unique case (avs_address_i)
			`BPO_PORT_OPTION_OFS: rd_mux = {16'h0000, r.port_option};
			`BPO_RETRY_LIMIT_OFS: rd_mux = r.retry_limit;
			`BPO_EVT_STATUS_OFS:  rd_mux = {30'h00000000, r.evt_status};
			`BPO_EVT_MASK_OFS:    rd_mux = {30'h00000000, r.evt_mask};
			default:              rd_mux = 32'h00000000;
		endcase
	end

	always_comb begin
		next_r = r;
		next_r.ack = access;
		next_r.timeout_pulse = 1'b0;
		evt_set = 2'b00;
		if (access && avs_read_i) begin
			next_r.rdata = rd_mux;
		end
		if (commit && avs_write_i) begin
			unique case (avs_address_i)
				`BPO_PORT_OPTION_OFS: begin
					next_r.port_option = (r.port_option
						& ~(wmask[15:0] & `BPO_PORT_WR_MASK))
						| (avs_writedata_i[15:0] & wmask[15:0]
						& `BPO_PORT_WR_MASK);
				end
				`BPO_RETRY_LIMIT_OFS: begin
					next_r.retry_limit = (r.retry_limit & ~wmask)
						| (avs_writedata_i & wmask);
				end
				`BPO_EVT_STATUS_OFS: begin
					next_r.evt_status = r.evt_status
						& ~(avs_writedata_i[1:0] & wmask[1:0]);
				end
				`BPO_EVT_MASK_OFS: begin
					next_r.evt_mask = (r.evt_mask & ~wmask[1:0])
						| (avs_writedata_i[1:0] & wmask[1:0]);
				end
				default: begin
				end
			endcase
		end
		unique case (r.state)
			BPO_IDLE: begin
				if (txn_start_i) begin
					next_r.attempts = 32'h00000000;
					next_r.posted = txn_posted_i;
					next_r.state = BPO_RETRY;
				end
			end
			BPO_RETRY: begin
				// A new transaction replaces the one still being retried.
				if (txn_start_i) begin
					next_r.attempts = 32'h00000000;
					next_r.posted = txn_posted_i;
				end else if (txn_done_i) begin
					next_r.state = BPO_IDLE;
				end else if (txn_retry_i) begin
					next_r.attempts = r.attempts + 32'h00000001;
					// A zero limit would never be reached, so it expires on the first retry.
					if (r.attempts + 32'h00000001 >= r.retry_limit) begin
						next_r.state = BPO_EXPIRED;
						next_r.timeout_pulse = 1'b1;
						evt_set[`BPO_EVT_TIMEOUT] = 1'b1;
						evt_set[`BPO_EVT_POSTED_FAIL] = r.posted;
					end
				end
			end
			BPO_EXPIRED: begin
				if (txn_start_i) begin
					next_r.attempts = 32'h00000000;
					next_r.posted = txn_posted_i;
					next_r.state = BPO_RETRY;
				end else if (txn_done_i) begin
					next_r.state = BPO_IDLE;
				end
			end
		endcase
		// Setting wins over a clear in the same cycle.
		next_r.evt_status = next_r.evt_status | evt_set;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			r.port_option   <= `BPO_PORT_OPTION_RST;
			r.retry_limit   <= `BPO_RETRY_LIMIT_RST;
			r.evt_status    <= 2'b00;
			r.evt_mask      <= 2'b00;
			r.attempts      <= 32'h00000000;
			r.state         <= BPO_IDLE;
			r.posted        <= 1'b0;
			r.timeout_pulse <= 1'b0;
			r.ack           <= 1'b0;
			r.rdata         <= 32'h00000000;
		end else begin
			r <= next_r;
		end
	end
endmodule // bpo_port_option_ctrl

/* File: common/bpo_defs.svh */
// Register offsets, field positions and reset values of the port option block.
`ifndef BPO_DEFS_SVH
`define BPO_DEFS_SVH
`define BPO_PORT_OPTION_OFS 8'h74
`define BPO_RETRY_LIMIT_OFS 8'h78
`define BPO_EVT_STATUS_OFS  8'h7c
`define BPO_EVT_MASK_OFS    8'h80
`define BPO_PRI_RD_ALIAS    1
`define BPO_PRI_WR_ALIAS    2
`define BPO_SEC_RD_ALIAS    3
`define BPO_SEC_WR_ALIAS    4
`define BPO_PRI_WI_DISC     7
`define BPO_SEC_WI_DISC     8
`define BPO_LONG_LOCK       9
`define BPO_SEC_HOLD_REQ    10
`define BPO_PRI_HOLD_REQ    11
`define BPO_PORT_WR_MASK    16'h0f9e
`define BPO_PORT_OPTION_RST 16'h0c00
`define BPO_RETRY_LIMIT_RST 32'h01000000
`define BPO_EVT_TIMEOUT     0
`define BPO_EVT_POSTED_FAIL 1
`define BPO_CMD_MEM_RD      4'h6
`define BPO_CMD_MEM_WR      4'h7
`define BPO_CMD_MEM_RD_MULT 4'hc
`define BPO_CMD_MEM_RD_LINE 4'he
`define BPO_CMD_MEM_WR_INV  4'hf
`endif

/* File: common/bpo_pkg.sv */
// Types shared by the port option block.
package bpo_pkg;
	typedef enum logic [2:0] {
		BPO_IDLE    = 3'b001,
		BPO_RETRY   = 3'b010,
		BPO_EXPIRED = 3'b100
	} bpo_state_type;

	// One side's view of a retried request against its pending transaction.
	typedef struct packed {
		logic [3:0] retry_cmd;
		logic [3:0] pending_cmd;
		logic       mwi_active;
		logic       line_boundary;
		logic       req_owned;
		logic       frame_seen;
		logic       fifo_empty;
		logic       target_term;
		logic       lock_cycle;
	} bpo_side_in_type;

	typedef struct packed {
		logic cmd_match;
		logic mwi_disconnect;
		logic mwi_to_plain;
		logic req_hold;
		logic long_lock_req;
	} bpo_side_out_type;
endpackage

/* File: verilog/bpo_side_ctrl.sv */
// Command matching, write-and-invalidate handling and request hold for one side.
`timescale 1ns/1ps
`include "bpo_defs.svh"
module bpo_side_ctrl
	import bpo_pkg::*;
(
	// Configuration.
	input  wire logic             rd_alias_i,
	input  wire logic             wr_alias_i,
	input  wire logic             wi_disc_i,
	input  wire logic             hold_req_i,
	input  wire logic             long_lock_i,
	// Side traffic.
	input  wire bpo_side_in_type  side_i,
	output bpo_side_out_type      side_o
);
	logic rd_alias_hit;
	logic wr_alias_hit;

	always_comb begin
		rd_alias_hit = rd_alias_i
			&& side_i.pending_cmd == `BPO_CMD_MEM_RD
			&& (side_i.retry_cmd == `BPO_CMD_MEM_RD_LINE
			|| side_i.retry_cmd == `BPO_CMD_MEM_RD_MULT);
		wr_alias_hit = wr_alias_i
			&& side_i.pending_cmd == `BPO_CMD_MEM_WR
			&& side_i.retry_cmd == `BPO_CMD_MEM_WR_INV;
		side_o.cmd_match = side_i.retry_cmd == side_i.pending_cmd
			|| rd_alias_hit || wr_alias_hit;
		side_o.mwi_to_plain = side_i.mwi_active && !wi_disc_i;
		side_o.mwi_disconnect = side_i.mwi_active && wi_disc_i
			&& side_i.line_boundary;
		// Long lock requests keep the grant for the whole locked sequence.
		side_o.long_lock_req = long_lock_i && side_i.lock_cycle;
		if (hold_req_i) begin
			side_o.req_hold = side_i.req_owned && !side_i.fifo_empty
				&& !side_i.target_term;
		end else begin
			side_o.req_hold = side_i.req_owned && !side_i.frame_seen;
		end
	end
endmodule // bpo_side_ctrl

/* File: tb/bpo_asserts.sv */
// Port-level checks for the port option block.
`timescale 1ns/1ps
module bpo_asserts
	import bpo_pkg::*;
(
	// Clock, reset and bus handshake.
	input wire logic             sys_clk_i,
	input wire logic             reset_i,
	input wire logic             avs_read_i,
	input wire logic             avs_write_i,
	input wire logic             avs_waitrequest_o,
	// Side traffic.
	input wire bpo_side_in_type  pri_side_i,
	input wire bpo_side_in_type  sec_side_i,
	input wire bpo_side_out_type pri_side_o,
	input wire bpo_side_out_type sec_side_o,
	// Retry sequencing.
	input wire logic             txn_start_i,
	input wire logic             txn_retry_i,
	input wire logic             txn_done_i,
	input wire logic             retry_stop_o,
	input wire logic             retry_timeout_o,
	input wire logic             primary_system_error_n_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_pulse;
		retry_timeout_o ##1 !retry_timeout_o;
	endsequence
	AST_BUS_ANSWER: assert property (s_req |=> !avs_waitrequest_o)
		else $error("bus answer late");
	AST_EXACT: assert property (pri_side_i.retry_cmd ==
		pri_side_i.pending_cmd |-> pri_side_o.cmd_match)
		else $error("exact command not matched");
	AST_ALIAS_ONLY: assert property (pri_side_o.cmd_match |->
		pri_side_i.retry_cmd == pri_side_i.pending_cmd ||
		(pri_side_i.pending_cmd == 4'h6 && pri_side_i.retry_cmd inside
		{4'hc, 4'he}) || (pri_side_i.pending_cmd == 4'h7 &&
		pri_side_i.retry_cmd == 4'hf)) else $error("false match");
	AST_MWI_EXCL: assert property (sec_side_i.mwi_active &&
		sec_side_i.line_boundary |->
		sec_side_o.mwi_to_plain ^ sec_side_o.mwi_disconnect)
		else $error("invalidate write neither converted nor cut");
	AST_MWI_DISC: assert property (pri_side_o.mwi_disconnect |->
		pri_side_i.mwi_active && pri_side_i.line_boundary)
		else $error("disconnect off boundary");
	AST_LOCK: assert property (pri_side_o.long_lock_req |->
		pri_side_i.lock_cycle) else $error("long request without lock");
	AST_HOLD_SEC: assert property (sec_side_o.req_hold |->
		sec_side_i.req_owned && (!sec_side_i.frame_seen ||
		(!sec_side_i.fifo_empty && !sec_side_i.target_term)))
		else $error("secondary request held wrongly");
	AST_HOLD_PRI: assert property (pri_side_o.req_hold |->
		pri_side_i.req_owned && (!pri_side_i.frame_seen ||
		(!pri_side_i.fifo_empty && !pri_side_i.target_term)))
		else $error("primary request held wrongly");
	AST_TMO_PULSE: assert property (retry_timeout_o |-> s_pulse)
		else $error("timeout not one cycle");
	AST_STOP_CAUSE: assert property ($rose(retry_stop_o) |->
		$past(txn_retry_i) && retry_timeout_o) else $error("stray stop");
	AST_START: assert property (txn_start_i |=> !retry_stop_o)
		else $error("start did not clear stop");
	AST_STOP_HOLD: assert property (retry_stop_o && !txn_start_i &&
		!txn_done_i |=> retry_stop_o) else $error("stop dropped early");
	AST_SERR: assert property ($fell(primary_system_error_n_o) |->
		retry_timeout_o) else $error("error without timeout");
endmodule // bpo_asserts
bind bpo_port_option_ctrl bpo_asserts u_asserts (.sys_clk_i(sys_clk_i),
	.reset_i(reset_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_waitrequest_o(avs_waitrequest_o), .pri_side_i(pri_side_i),
	.sec_side_i(sec_side_i), .pri_side_o(pri_side_o),
	.sec_side_o(sec_side_o), .txn_start_i(txn_start_i),
	.txn_retry_i(txn_retry_i), .txn_done_i(txn_done_i),
	.retry_stop_o(retry_stop_o),
	.retry_timeout_o(retry_timeout_o),
	.primary_system_error_n_o(primary_system_error_n_o));

/* File: tb/bpo_bus_model.sv */
// Far-side bus party presenting one side's command and master state.
`timescale 1ns/1ps
module bpo_bus_model
	import bpo_pkg::*;
(
	// Clock and commanded state.
	input  wire logic       sys_clk_i,
	input  wire logic [3:0] retry_cmd_i,
	input  wire logic [3:0] pending_cmd_i,
	input  wire logic [6:0] flags_i,
	// Side signals towards the bridge.
	output bpo_side_in_type side_o
);
	// Launched from a register so every change lands just after an edge.
	always_ff @(posedge sys_clk_i) begin
		side_o <= {retry_cmd_i, pending_cmd_i, flags_i};
	end
endmodule // bpo_bus_model

/* File: tb/testbench.sv */
// Register and side-control tests for the port option block.
`timescale 1ns/1ps
module testbench
	import bpo_pkg::*;
;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             rd = 1'b0;
	logic             wr = 1'b0;
	logic [7:0]       adr = 8'h00;
	logic [31:0]      wd = 32'h0;
	logic [31:0]      rdat, q;
	logic [3:0]       rc = 4'h0, pc = 4'h0, tx = 4'h0;
	logic [6:0]       fl = 7'h00;
	logic [3:0]       be = 4'hf;
	logic [3:0]       rt [4] = '{4'he, 4'hc, 4'hf, 4'h7};
	logic [3:0]       pt [4] = '{4'h6, 4'h6, 4'h7, 4'h7};
	logic [31:0]      ov [3] = '{32'h0, 32'h0f9e, 32'h0886};
	logic [4:0]       pe [3] = '{5'h04, 5'h1b, 5'h1a};
	logic [4:0]       se [3] = '{5'h04, 5'h1b, 5'h04};
	bpo_side_in_type  pi, si;
	bpo_side_out_type po, so;
	logic             wrq, stop, tmo, serr_n, irq;
	int               num_errors = 0;
	int               tests_run = 0;
	bpo_port_option_ctrl dut (.sys_clk_i(clk), .reset_i(rst),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(be),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .pri_side_i(pi),
		.sec_side_i(si), .pri_side_o(po), .sec_side_o(so),
		.txn_start_i(tx[3]), .txn_retry_i(tx[2]), .txn_done_i(tx[1]),
		.txn_posted_i(tx[0]), .retry_stop_o(stop), .retry_timeout_o(tmo),
		.primary_system_error_n_o(serr_n), .irq_o(irq));
	bpo_bus_model pri_m (.sys_clk_i(clk), .retry_cmd_i(rc),
		.pending_cmd_i(pc), .flags_i(fl), .side_o(pi));
	bpo_bus_model sec_m (.sys_clk_i(clk), .retry_cmd_i(rc),
		.pending_cmd_i(pc), .flags_i(fl), .side_o(si));
	task automatic chk(input string n, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		@(posedge clk iff !wrq);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Pulses start, retry and done; the returned edge shows the result.
	task automatic txn(input logic [3:0] k);
		@(posedge clk);
		tx <= k;
		@(posedge clk);
		tx <= 4'h0;
		@(posedge clk);
	endtask
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		#20000;
		num_errors++;
		give_verdict;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		bus(0, 8'h74, 0);
		chk("opt_reset", q, 32'h0c00);
		bus(0, 8'h78, 0);
		chk("limit_reset", q, 32'h0100_0000);
		bus(1, 8'h74, 32'hffff_ffff);
		bus(0, 8'h74, 0);
		chk("opt_reserved", q, 32'h0f9e);
		bus(1, 8'hf0, 32'h5a5a_5a5a);
		bus(0, 8'hf0, 0);
		chk("unmapped", q, 32'h0);
		// Frame seen, so only a hold-longer master keeps its request.
		fl <= 7'b1111001;
		for (int v = 0; v < 3; v++)
			for (int i = 0; i < 4; i++) begin
				bus(1, 8'h74, ov[v]);
				rc <= rt[i];
				pc <= pt[i];
				repeat (2) @(posedge clk);
				chk("pri_match", po[4], pe[v][4] | (i == 3));
				chk("pri_rest", po[3:0], pe[v][3:0]);
				chk("sec_match", so[4], se[v][4] | (i == 3));
				chk("sec_rest", so[3:0], se[v][3:0]);
			end
		bus(1, 8'h78, 32'h3);
		bus(0, 8'h78, 0);
		chk("limit", q, 32'h3);
		bus(1, 8'h80, 32'h3);
		txn(4'h9);
		txn(4'h4);
		txn(4'h4);
		chk("early", {serr_n, stop, tmo}, 3'b100);
		txn(4'h4);
		chk("expired", {serr_n, stop, irq, tmo}, 4'b0111);
		bus(0, 8'h7c, 0);
		chk("status", q, 32'h3);
		chk("pulse_end", tmo, 1'b0);
		bus(1, 8'h80, 0);
		@(posedge clk);
		chk("masked", irq, 1'b0);
		bus(1, 8'h7c, 32'h3);
		bus(1, 8'h80, 32'h3);
		@(posedge clk);
		chk("cleared", {serr_n, irq}, 2'b10);
		txn(4'h8);
		chk("restart", stop, 1'b0);
		txn(4'h4);
		txn(4'h4);
		txn(4'h4);
		chk("nonposted", {serr_n, stop, irq}, 3'b111);
		txn(4'h2);
		chk("done", stop, 1'b0);
		be <= 4'h2;
		bus(1, 8'h78, 32'hffff_ffff);
		be <= 4'hf;
		bus(0, 8'h78, 0);
		chk("lanes", q, 32'h0000_ff03);
		give_verdict;
	end
endmodule // testbench
